// *** inc/scp_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the clock control block.
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define SCP_ADDR_PRESCALER 8'h30
`define SCP_ADDR_PLL_CSR 8'h31
`define SCP_ADDR_PLL_FRQ 8'h32

// ---------------------------------------------------------------------------
// Prescaler control fields
// ---------------------------------------------------------------------------
`define SCP_PCE_BIT 7
`define SCP_PCE_ARM_VALUE 8'h80
`define SCP_PCE_WINDOW_CYCLES 3'h4
`define SCP_CODE_DIV1 4'h0
`define SCP_CODE_DIV8 4'h3
`define SCP_CODE_MAX 4'h8

// ---------------------------------------------------------------------------
// PLL control and status fields
// ---------------------------------------------------------------------------
`define SCP_PLL_INPUT_HALVING_BIT 4
`define SCP_PLL_ENABLE_BIT 1
`define SCP_PLL_LOCK_FLAG_BIT 0

// ---------------------------------------------------------------------------
// PLL frequency control fields
// ---------------------------------------------------------------------------
`define SCP_PLL_FREQUENCY_CONTROL_RESET 8'h04
`define SCP_PLL_SOURCE_SELECT_BIT 7
`define SCP_USB_POSTDIVIDER_BIT 6
`define SCP_TIMER_POSTDIVIDER_MSB 5
`define SCP_TIMER_POSTDIVIDER_LSB 4
`define SCP_VCO_FREQUENCY_SELECT_MSB 3
`define SCP_VCO_FREQUENCY_SELECT_LSB 0
`define SCP_TM_OFF 2'h0
`define SCP_TM_DIV1 2'h1
`define SCP_TM_DIV1P5 2'h2
`define SCP_TM_DIV2 2'h3

`endif

// *** inc/scp_pkg.sv ***
// Types shared by the clock control block.
`default_nettype none
package scp_pkg;

  typedef enum logic [0:0] {SCP_PCE_CLOSED, SCP_PCE_OPEN} scp_pce_e;

  typedef enum logic [1:0] {SCP_SEL_NONE, SCP_SEL_PRESC, SCP_SEL_CSR, SCP_SEL_FRQ} scp_reg_sel_e;

endpackage : scp_pkg
`default_nettype wire

// *** rtl/scp_sysclk_div.sv ***
// Power-of-two system clock divider that emits one enable pulse per divided period.
`default_nettype none
`include "scp_regs.svh"
module scp_sysclk_div (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] div_code_i,
  output logic tick_o,
  output logic [3:0] active_code_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [3:0] code;
    logic tick;
  } scp_div_s;

  scp_div_s st;
  scp_div_s next_st;

  // Reserved codes are undefined; they are held at the slowest legal rate.
  function automatic logic [3:0] scp_clamp(input logic [3:0] code);
    scp_clamp = (code > `SCP_CODE_MAX) ? `SCP_CODE_MAX : code;
  endfunction : scp_clamp

  function automatic logic [7:0] scp_last(input logic [3:0] code);
    logic [8:0] span;
    span = 9'h001 << scp_clamp(code);
    scp_last = 8'(span - 9'h001);
  endfunction : scp_last

  // A new code is taken only at the end of a full period, so no shortened period ever appears.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == scp_last(st.code)) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b1;
      next_st.code = scp_clamp(div_code_i);
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
    if (!rst_n_i) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b0;
      next_st.code = scp_clamp(div_code_i);
    end
  end

  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  assign tick_o = st.tick;
  assign active_code_o = st.code;

endmodule : scp_sysclk_div
`default_nettype wire

// *** rtl/scp_pll_postdiv.sv ***
// PLL post-dividers that pace the USB and high-speed timer clock enables.
`default_nettype none
`include "scp_regs.svh"
module scp_pll_postdiv (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic usb_half_i,
  input wire logic [1:0] tim_code_i,
  output logic usb_tick_o,
  output logic tim_tick_o
);

  typedef struct packed {
    logic half;
    logic [1:0] phase;
    logic usb_tick;
    logic tim_tick;
  } scp_post_s;

  scp_post_s st;
  scp_post_s next_st;

  always_comb begin
    next_st = st;
    next_st.half = ~st.half;
    next_st.phase = (st.phase == 2'h2) ? 2'h0 : st.phase + 2'h1;
    next_st.usb_tick = run_i & (~usb_half_i | st.half);
    // Two pulses in three cycles alternate gaps of one and two: exact mean rate, some jitter.
    unique case (tim_code_i)
      `SCP_TM_OFF: next_st.tim_tick = 1'b0;
      `SCP_TM_DIV1: next_st.tim_tick = run_i;
      `SCP_TM_DIV1P5: next_st.tim_tick = run_i & (st.phase != 2'h2);
      `SCP_TM_DIV2: next_st.tim_tick = run_i & st.half;
    endcase
    if (!rst_n_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  assign usb_tick_o = st.usb_tick;
  assign tim_tick_o = st.tim_tick;

endmodule : scp_pll_postdiv
`default_nettype wire

// *** rtl/scp_clock_ctrl.sv ***
// System clock prescaler and PLL clock tree control with its register port.
//
// Function
// - Change enable is set only by a write of that bit alone.
// - Change enable clears four cycles after setting, or when the division is written.
// - Rewriting change enable inside the window neither restarts nor clears it.
// - The division field loads only while change enable is set.
// - Codes 0 to 8 divide by 1 to 256; higher codes are reserved.
// - Reset loads division 0000, or 0011 when the divide-by-eight fuse is programmed.
// - Any division code may be written at run time, whatever the fuse.
// - The chosen division paces the processor and all synchronous peripherals alike.
// - PLL enable starts the PLL and, with internal source, the RC oscillator.
// - Lock flag reads one when locked; only clearing PLL enable clears it.
// - Status register bits 7..5 and 3..2 always read zero.
// - Source select picks the halving path or the internal RC oscillator.
// - USB post-divider passes the PLL output or halves it.
// - Timer post-divider disconnects at 00, else divides by 1, 1.5 or 2.
// - Division by 1.5 alternates periods of one and two cycles: exact mean rate, some jitter.
// - VCO select 0010 to 1010 gives 32 to 96 MHz in 8 MHz steps.
// - Division changes make no glitch nor any faster intermediate rate.
`default_nettype none
`include "scp_regs.svh"
module scp_clock_ctrl (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic divide_by_eight_fuse_i,
  input wire logic pll_lock_detect_i,
  output logic [7:0] rd_data_o,
  output logic sys_clk_en_o,
  output logic [3:0] active_division_o,
  output logic pll_enable_o,
  output logic pll_input_halving_o,
  output logic pll_source_select_o,
  output logic [3:0] vco_frequency_select_o,
  output logic rc_osc_on_o,
  output logic pll_lock_flag_o,
  output logic usb_clk_en_o,
  output logic tim_clk_en_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] fuse_sync;
    logic [2:0] lock_sync;
    scp_pkg::scp_pce_e pce_state;
    logic [2:0] pce_cnt;
    logic [3:0] clock_division_select;
    logic pll_input_halving;
    logic pll_enable;
    logic pll_lock_flag;
    logic [7:0] pll_frequency_control;
    logic rc_osc_on;
    logic [7:0] rd_data;
  } scp_ctrl_s;

  scp_ctrl_s st;
  scp_ctrl_s next_st;

  logic sys_tick;
  logic [3:0] sys_code;
  logic usb_tick;
  logic tim_tick;

  // ---------------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------------
  function automatic scp_pkg::scp_reg_sel_e scp_decode(input logic [7:0] addr);
    unique case (addr)
      `SCP_ADDR_PRESCALER: scp_decode = scp_pkg::SCP_SEL_PRESC;
      `SCP_ADDR_PLL_CSR: scp_decode = scp_pkg::SCP_SEL_CSR;
      `SCP_ADDR_PLL_FRQ: scp_decode = scp_pkg::SCP_SEL_FRQ;
      default: scp_decode = scp_pkg::SCP_SEL_NONE;
    endcase
  endfunction : scp_decode

  // Fuse level after the synchroniser; only the last two stages are compared.
  function automatic logic scp_fuse_agreed(input logic [2:0] sync);
    scp_fuse_agreed = sync[1] & sync[2];
  endfunction : scp_fuse_agreed

  function automatic logic [3:0] scp_fuse_code(input logic programmed);
    scp_fuse_code = programmed ? `SCP_CODE_DIV8 : `SCP_CODE_DIV1;
  endfunction : scp_fuse_code

  function automatic logic [7:0] scp_presc_word(input scp_ctrl_s s);
    logic pce;
    pce = (s.pce_state == scp_pkg::SCP_PCE_OPEN);
    scp_presc_word = {pce, 3'h0, s.clock_division_select};
  endfunction : scp_presc_word

  function automatic logic [7:0] scp_csr_word(input scp_ctrl_s s);
    logic [7:0] w;
    w = 8'h00;
    w[`SCP_PLL_INPUT_HALVING_BIT] = s.pll_input_halving;
    w[`SCP_PLL_ENABLE_BIT] = s.pll_enable;
    w[`SCP_PLL_LOCK_FLAG_BIT] = s.pll_lock_flag;
    scp_csr_word = w;
  endfunction : scp_csr_word

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    scp_pkg::scp_reg_sel_e wsel;
    scp_pkg::scp_reg_sel_e rsel;
    logic lock_seen;
    logic is_arm;
    wsel = scp_decode(addr_i);
    rsel = scp_decode(addr_i);
    lock_seen = st.lock_sync[1] & st.lock_sync[2];
    is_arm = (wr_data_i == `SCP_PCE_ARM_VALUE);
    next_st = st;

    // Pins from outside the clock domain pass three flip-flops.
    next_st.fuse_sync = {st.fuse_sync[1:0], divide_by_eight_fuse_i};
    next_st.lock_sync = {st.lock_sync[1:0], pll_lock_detect_i};

    // Change enable window countdown.
    if (st.pce_state == scp_pkg::SCP_PCE_OPEN) begin
      if (st.pce_cnt == 3'h1) begin
        next_st.pce_state = scp_pkg::SCP_PCE_CLOSED;
        next_st.pce_cnt = 3'h0;
      end else begin
        next_st.pce_cnt = st.pce_cnt - 3'h1;
      end
    end

    // Prescaler register writes.
    if (wr_i && wsel == scp_pkg::SCP_SEL_PRESC) begin
      unique case (st.pce_state)
        scp_pkg::SCP_PCE_CLOSED: begin
          if (is_arm) begin
            next_st.pce_state = scp_pkg::SCP_PCE_OPEN;
            next_st.pce_cnt = `SCP_PCE_WINDOW_CYCLES;
          end
        end
        scp_pkg::SCP_PCE_OPEN: begin
          // A repeated arm write is ignored so the window cannot be stretched.
          if (!is_arm) begin
            next_st.clock_division_select = wr_data_i[3:0];
            next_st.pce_state = scp_pkg::SCP_PCE_CLOSED;
            next_st.pce_cnt = 3'h0;
          end
        end
      endcase
    end

    // PLL control and status register writes.
    if (wr_i && wsel == scp_pkg::SCP_SEL_CSR) begin
      next_st.pll_input_halving = wr_data_i[`SCP_PLL_INPUT_HALVING_BIT];
      next_st.pll_enable = wr_data_i[`SCP_PLL_ENABLE_BIT];
    end

    // PLL frequency control register writes.
    if (wr_i && wsel == scp_pkg::SCP_SEL_FRQ) begin
      next_st.pll_frequency_control = wr_data_i;
    end

    // Lock is sticky while the PLL stays enabled; a same-cycle write clearing enable wins over the set.
    if (!next_st.pll_enable) begin
      next_st.pll_lock_flag = 1'b0;
    end else if (st.pll_enable && lock_seen) begin
      next_st.pll_lock_flag = 1'b1;
    end

    // The internal RC oscillator must run whenever the PLL takes it as source.
    next_st.rc_osc_on = next_st.pll_enable &
                        next_st.pll_frequency_control[`SCP_PLL_SOURCE_SELECT_BIT];

    // Read data stand in the cycle after the strobe only.
    next_st.rd_data = 8'h00;
    if (rd_i) begin
      unique case (rsel)
        scp_pkg::SCP_SEL_PRESC: next_st.rd_data = scp_presc_word(st);
        scp_pkg::SCP_SEL_CSR: next_st.rd_data = scp_csr_word(st);
        scp_pkg::SCP_SEL_FRQ: next_st.rd_data = st.pll_frequency_control;
        scp_pkg::SCP_SEL_NONE: next_st.rd_data = 8'h00;
      endcase
    end

    // Synchronous reset; the synchronisers keep shifting so the fuse is seen while reset is held.
    if (!rst_n_i) begin
      next_st.pce_state = scp_pkg::SCP_PCE_CLOSED;
      next_st.pce_cnt = 3'h0;
      next_st.clock_division_select = scp_fuse_code(scp_fuse_agreed(st.fuse_sync));
      next_st.pll_input_halving = 1'b0;
      next_st.pll_enable = 1'b0;
      next_st.pll_lock_flag = 1'b0;
      next_st.pll_frequency_control = `SCP_PLL_FREQUENCY_CONTROL_RESET;
      next_st.rc_osc_on = 1'b0;
      next_st.rd_data = 8'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------------------
  // Clock dividers
  // ---------------------------------------------------------------------------
  // One enable pulse paces every synchronous consumer, so all slow down together.
  scp_sysclk_div u_sysclk_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .div_code_i(st.clock_division_select),
    .tick_o(sys_tick),
    .active_code_o(sys_code)
  );

  // Post-divider pacing is held off until lock, since an unlocked VCO is not trusted.
  scp_pll_postdiv u_pll_postdiv (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .run_i(st.pll_lock_flag),
    .usb_half_i(st.pll_frequency_control[`SCP_USB_POSTDIVIDER_BIT]),
    .tim_code_i(st.pll_frequency_control[`SCP_TIMER_POSTDIVIDER_MSB:`SCP_TIMER_POSTDIVIDER_LSB]),
    .usb_tick_o(usb_tick),
    .tim_tick_o(tim_tick)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rd_data_o = st.rd_data;
  assign sys_clk_en_o = sys_tick;
  assign active_division_o = sys_code;
  assign pll_enable_o = st.pll_enable;
  assign pll_input_halving_o = st.pll_input_halving;
  assign pll_source_select_o = st.pll_frequency_control[`SCP_PLL_SOURCE_SELECT_BIT];
  assign vco_frequency_select_o = st.pll_frequency_control[`SCP_VCO_FREQUENCY_SELECT_MSB:`SCP_VCO_FREQUENCY_SELECT_LSB];
  assign rc_osc_on_o = st.rc_osc_on;
  assign pll_lock_flag_o = st.pll_lock_flag;
  assign usb_clk_en_o = usb_tick;
  assign tim_clk_en_o = tim_tick;

endmodule : scp_clock_ctrl
`default_nettype wire

// *** testbench/scp_clock_ctrl_assertions.sv ***
// Concurrent checks on the ports of the clock control block.
`default_nettype none
`include "scp_regs.svh"
module scp_clock_ctrl_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic divide_by_eight_fuse_i,
  input wire logic [7:0] rd_data_o,
  input wire logic sys_clk_en_o,
  input wire logic [3:0] active_division_o,
  input wire logic pll_enable_o,
  input wire logic pll_source_select_o,
  input wire logic [3:0] vco_frequency_select_o,
  input wire logic rc_osc_on_o,
  input wire logic pll_lock_flag_o,
  input wire logic usb_clk_en_o,
  input wire logic tim_clk_en_o
);
  // Starts saturated so the first period after reset is never judged short.
  logic [8:0] gap;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      gap <= 9'h1FF;
    end else if (sys_clk_en_o) begin
      gap <= 9'h000;
    end else if (gap != 9'h1FF) begin
      gap <= gap + 9'h001;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  csr_reserved_zero_a:
    assert property ($past(rd_i && addr_i == `SCP_ADDR_PLL_CSR) |-> rd_data_o[7:5] == 3'h0 && rd_data_o[3:2] == 2'h0)
      else $error("reserved status bits read nonzero");
  csr_read_state_a:
    assert property ($past(rd_i && addr_i == `SCP_ADDR_PLL_CSR) |-> rd_data_o[1:0] == $past({pll_enable_o, pll_lock_flag_o}))
      else $error("status read does not match enable and lock");
  frq_read_state_a:
    assert property ($past(rd_i && addr_i == `SCP_ADDR_PLL_FRQ) |->
      rd_data_o[7] == $past(pll_source_select_o) && rd_data_o[3:0] == $past(vco_frequency_select_o))
      else $error("frequency read does not match outputs");
  lock_needs_enable_a:
    assert property (pll_lock_flag_o |-> pll_enable_o)
      else $error("lock flag set without enable");
  lock_holds_a:
    assert property ($past(pll_lock_flag_o) && pll_enable_o |-> pll_lock_flag_o)
      else $error("lock flag dropped while enabled");
  rc_osc_request_a:
    assert property (rc_osc_on_o == (pll_enable_o && pll_source_select_o))
      else $error("oscillator request wrong");
  post_gate_a:
    assert property (!$past(pll_lock_flag_o) |-> !usb_clk_en_o && !tim_clk_en_o)
      else $error("post divider pulse while unlocked");
  div_clamp_a:
    assert property (active_division_o <= `SCP_CODE_MAX)
      else $error("division code above maximum");
  no_short_period_a:
    assert property (sys_clk_en_o |-> ({1'b0, gap} + 10'h001) >= (10'h001 << ((active_division_o <
      $past(active_division_o)) ? active_division_o : $past(active_division_o))))
      else $error("system clock period too short");
  reset_code_a:
    assert property (!$past(rst_n_i) |->
      active_division_o == (divide_by_eight_fuse_i ? `SCP_CODE_DIV8 : `SCP_CODE_DIV1))
      else $error("reset division does not follow fuse");
endmodule : scp_clock_ctrl_chk
bind scp_clock_ctrl scp_clock_ctrl_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
  .divide_by_eight_fuse_i(divide_by_eight_fuse_i), .rd_data_o(rd_data_o), .sys_clk_en_o(sys_clk_en_o),
  .active_division_o(active_division_o), .pll_enable_o(pll_enable_o), .pll_source_select_o(pll_source_select_o),
  .vco_frequency_select_o(vco_frequency_select_o), .rc_osc_on_o(rc_osc_on_o), .pll_lock_flag_o(pll_lock_flag_o),
  .usb_clk_en_o(usb_clk_en_o), .tim_clk_en_o(tim_clk_en_o));
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the clock control block.
`default_nettype none
`include "scp_regs.svh"
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fuse = 1'b0;
  logic lock_det = 1'b0;
  logic [7:0] rd_data_o;
  logic [3:0] act, vco;
  logic sys_en, pll_en, halving, src_sel, rc_on, lock, usb_en, tim_en;
  int miscompares = 0;
  int samples_checked = 0;
  int n, u, t, c;
  int tim_exp[4] = '{0, 12, 8, 6};
  scp_clock_ctrl u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .divide_by_eight_fuse_i(fuse), .pll_lock_detect_i(lock_det), .rd_data_o(rd_data_o),
    .sys_clk_en_o(sys_en), .active_division_o(act), .pll_enable_o(pll_en), .pll_input_halving_o(halving),
    .pll_source_select_o(src_sel), .vco_frequency_select_o(vco), .rc_osc_on_o(rc_on), .pll_lock_flag_o(lock),
    .usb_clk_en_o(usb_en), .tim_clk_en_o(tim_en));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask : tick
  // A write strobe is held until the next task call, so writes can run back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wr_data_i <= d;
  endtask : wr
  task automatic idle;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : idle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    `CHECK(rd_data_o, e)
  endtask : rd
  task automatic pce(input int gap, input logic [7:0] code, input logic [7:0] e);
    wr(`SCP_ADDR_PRESCALER, `SCP_PCE_ARM_VALUE);
    repeat (gap) idle();
    wr(`SCP_ADDR_PRESCALER, code);
    rd(`SCP_ADDR_PRESCALER, e);
  endtask : pce
  task automatic period(input logic [3:0] code, output int p);
    int i;
    int j;
    for (i = 0; i < 600 && act !== code; i++) tick();
    for (j = 0; j < 600 && sys_en !== 1'b1; j++) tick();
    tick();
    for (p = 1; p < 600 && sys_en !== 1'b1; p++) tick();
    // A wait that runs out of its bound is a failure in itself.
    if (i == 600 || j == 600 || p == 600) begin
      miscompares++;
      finish_test();
    end
  endtask : period
  task automatic pulses(output int pu, output int pt);
    pu = 0;
    pt = 0;
    repeat (12) begin
      tick();
      pu += (usb_en === 1'b1);
      pt += (tim_en === 1'b1);
    end
  endtask : pulses
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (100000) @(posedge clock_i);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(`SCP_ADDR_PRESCALER, 8'h00);
    rd(`SCP_ADDR_PLL_CSR, 8'h00);
    rd(`SCP_ADDR_PLL_FRQ, `SCP_PLL_FREQUENCY_CONTROL_RESET);
    rd(8'h40, 8'h00);
    $display("reset values done");
    for (c = 0; c <= 8; c++) begin
      pce(0, c[7:0], c[7:0]);
      period(c[3:0], n);
      `CHECK(n, 1 << c)
    end
    wr(`SCP_ADDR_PRESCALER, 8'h05);
    rd(`SCP_ADDR_PRESCALER, 8'h08);
    wr(`SCP_ADDR_PRESCALER, 8'h81);
    wr(`SCP_ADDR_PRESCALER, 8'h01);
    rd(`SCP_ADDR_PRESCALER, 8'h08);
    pce(3, 8'h02, 8'h02);
    pce(4, 8'h01, 8'h02);
    // The second arm lands one edge after the first; the code write lands on the fifth edge after the first arm.
    wr(`SCP_ADDR_PRESCALER, `SCP_PCE_ARM_VALUE);
    wr(`SCP_ADDR_PRESCALER, `SCP_PCE_ARM_VALUE);
    rd(`SCP_ADDR_PRESCALER, 8'h82);
    idle();
    wr(`SCP_ADDR_PRESCALER, 8'h01);
    rd(`SCP_ADDR_PRESCALER, 8'h02);
    pce(0, 8'h09, 8'h09);
    period(`SCP_CODE_MAX, n);
    `CHECK(n, 256)
    $display("prescaler done");
    wr(8'h40, 8'hFF);
    wr(`SCP_ADDR_PLL_FRQ, 8'hEA);
    rd(`SCP_ADDR_PLL_FRQ, 8'hEA);
    `CHECK({src_sel, vco}, 5'h1A)
    wr(`SCP_ADDR_PLL_CSR, 8'h10);
    wr(`SCP_ADDR_PLL_CSR, 8'hFF);
    rd(`SCP_ADDR_PLL_CSR, 8'h12);
    `CHECK({rc_on, halving, pll_en}, 3'h7)
    pulses(u, t);
    `CHECK(u + t, 0)
    @(posedge clock_i);
    lock_det <= 1'b1;
    for (c = 0; c < 20 && lock !== 1'b1; c++) tick();
    if (lock !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd(`SCP_ADDR_PLL_CSR, 8'h13);
    @(posedge clock_i);
    lock_det <= 1'b0;
    pulses(u, t);
    `CHECK(lock, 1'b1)
    `CHECK(u, 6)
    `CHECK(t, 8)
    for (c = 0; c < 4; c++) begin
      wr(`SCP_ADDR_PLL_FRQ, {2'h2, c[1:0], 4'hA});
      idle();
      tick();
      pulses(u, t);
      `CHECK(t, tim_exp[c])
      `CHECK(u, 12)
    end
    wr(`SCP_ADDR_PLL_CSR, 8'h10);
    idle();
    tick();
    `CHECK({lock, rc_on, pll_en}, 3'h0)
    $display("pll done");
    @(posedge clock_i);
    fuse <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(`SCP_ADDR_PRESCALER, 8'h03);
    period(`SCP_CODE_DIV8, n);
    `CHECK(n, 8)
    pce(0, 8'h00, 8'h00);
    period(`SCP_CODE_DIV1, n);
    `CHECK(n, 1)
    $display("fuse reset done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
